//--- rtl/txset_pkg.sv
// constants, field layout and register map of the transmit data set manager
//
// Operation
// - five-bit byte-count field, bits 4:0, one ring entry per data set
// - function interface takes the send length from the stored count of that set
// - two read-only armed flags; one means that set is written and ready
// - after reset both armed flags read zero, the FIFO holds no sets
// - none or only set one armed: fill set zero; only set zero: set one
// - both sets armed: data port and byte-count writes are ignored
// - the armed flag rises on the byte-count write, never on data writes
// - after an automatic, non-isochronous acknowledge the flags update at the same edge as the marker advance
// - isochronous flag update after a completed transfer waits for start-of-frame
// - automatic management off: marker, pointer and flags untouched at transfer end
// - automatic, not isochronous, acknowledge: advance marker, clear that set's flag
// - automatic, not isochronous, error: reverse read pointer, keep that flag
// - automatic and isochronous: advance marker on acknowledge or error, clear flag at start-of-frame
// - byte count zero with no data arms a zero-length packet
// - flush bit empties FIFO, resets pointers, markers, flags, then self-clears
// - read pointer steps by one after each byte read by the function interface
package txset_pkg;

  // --------------------------------------------------------------------------
  // register indices; byte address is four times the index
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_DATA  = 8'hF3;
  localparam logic [7:0] IDX_CTRL  = 8'hF4;
  localparam logic [7:0] IDX_COUNT = 8'hF6;
  localparam logic [7:0] IDX_FLAGS = 8'hF8;
  localparam logic [7:0] IDX_STAT  = 8'hF9;

  // --------------------------------------------------------------------------
  // field layout and reset values
  // --------------------------------------------------------------------------
  localparam int         ADDR_W     = 12;
  localparam int         COUNT_W    = 5;
  localparam int         PTR_W      = 4;
  localparam int         DEPTH      = 16;
  localparam int         BIT_FLUSH  = 7;
  localparam int         BIT_ISO    = 3;
  localparam int         BIT_ATM    = 2;
  localparam int         BIT_ADV    = 1;
  localparam int         BIT_REV    = 0;
  localparam int         BIT_ERR    = 1;
  localparam int         BIT_ACK    = 0;
  localparam logic       ATM_RESET  = 1'b1;
  localparam logic       ISO_RESET  = 1'b0;
  localparam logic [1:0] ARMED_NONE = 2'h0;
  localparam logic [1:0] ARMED_ZERO = 2'h1;
  localparam logic [1:0] ARMED_ONE  = 2'h2;
  localparam logic [1:0] ARMED_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;

  typedef logic [PTR_W-1:0]   ptr_t;
  typedef logic [COUNT_W-1:0] count_t;

endpackage

//--- rtl/ring_if.sv
// carrier between the set manager and the byte ring
interface ring_if;
  import txset_pkg::*;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       rd_en;
  logic       adv;
  logic       rev;
  logic       flush;
  logic [7:0] rd_data;
  logic       empty;

  modport ctrl (output wr_en, wr_data, rd_en, adv, rev, flush, input rd_data, empty);
  modport ring (input wr_en, wr_data, rd_en, adv, rev, flush, output rd_data, empty);
endinterface

//--- rtl/byte_ring.sv
// byte storage with write pointer, read pointer and read marker
module byte_ring
  import txset_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  ring_if.ring      rif
);

  logic [7:0] mem [DEPTH];
  ptr_t       wptr;
  ptr_t       rptr;
  ptr_t       marker;
  ptr_t       one;

  assign one = ptr_t'(1);

  // ------------------------------------------------------------------
  // storage; contents are not cleared, only the pointers are
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (rif.wr_en) begin
      mem[wptr] <= rif.wr_data;
    end
  end

  // write pointer steps after each stored byte
  always_ff @(posedge aclk) begin
    if (!aresetn || rif.flush) begin
      wptr <= '0;
    end else if (rif.wr_en) begin
      wptr <= wptr + one;
    end
  end

  // read pointer: steps per byte, reverses to the marker on retry
  always_ff @(posedge aclk) begin
    if (!aresetn || rif.flush) begin
      rptr <= '0;
    end else if (rif.rev) begin
      rptr <= marker;
    end else if (rif.rd_en) begin
      rptr <= rptr + one;
    end
  end

  // read marker follows the read pointer once a set is done
  always_ff @(posedge aclk) begin
    if (!aresetn || rif.flush) begin
      marker <= '0;
    end else if (rif.adv) begin
      marker <= rptr;
    end
  end

  // byte handed out is registered at the read step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rif.rd_data <= 8'h00;
    end else if (rif.rd_en) begin
      rif.rd_data <= mem[rptr];
    end
  end

  // empty when every stored byte has been taken by the marker
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rif.empty <= 1'b1;
    end else begin
      rif.empty <= (marker == wptr);
    end
  end

endmodule

//--- rtl/tx_set_manager.sv
// transmit data set manager with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite slave port.
module tx_set_manager
  import txset_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire logic              fi_byte_rd,
  output var  logic [7:0]        fi_byte,
  output var  logic [COUNT_W-1:0] fi_count,
  output var  logic              fi_set_ready,
  input  wire logic              fi_done,
  input  wire logic              fi_ack,
  input  wire logic              fi_err,
  input  wire logic              sof
);

  ring_if rif ();

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // captured write channels
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  // write decode strobes
  logic              wr_fire;
  logic              wr_hit;
  logic [7:0]        wr_idx;
  logic [7:0]        rd_idx;
  logic              lane0;
  logic              data_wr;
  logic              count_wr;
  logic              ctrl_wr;
  logic              flush;
  // mode bits and set bookkeeping
  logic              iso;
  logic              auto_transmit_management;
  logic [1:0]        armed;
  logic [1:0]        next_armed;
  logic              order;
  logic              next_order;
  logic              pend;
  logic              next_pend;
  logic              pend_set;
  logic              next_pend_set;
  logic              send_set;
  logic              write_set;
  // end of transfer actions
  logic              done_adv;
  logic              done_rev;
  logic              done_clear;
  logic              done_defer;
  logic              man_adv;
  logic              man_rev;
  // status and read path
  logic              last_ack;
  logic              last_err;
  count_t            count_ring [2];
  logic [31:0]       rd_word;
  logic              rd_hit;

  // ------------------------------------------------------------------
  // byte ring
  // ------------------------------------------------------------------
  byte_ring i_byte_ring (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rif     (rif)
  );

  assign rif.wr_en   = data_wr;
  assign rif.wr_data = w_data[7:0];
  assign rif.rd_en   = fi_byte_rd;
  assign rif.adv     = done_adv | man_adv;
  assign rif.rev     = done_rev | man_rev;
  assign rif.flush   = flush;

  // ------------------------------------------------------------------
  // AXI write channels: address and data taken in either order
  // ------------------------------------------------------------------
  // each channel is held until its partner arrives, then both retire together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      awready <= 1'b0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
      awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !bvalid) begin
      awready <= 1'b1;
    end
  end

  // data channel mirrors the address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      wready <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
      wready <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (!w_held && !bvalid) begin
      wready <= 1'b1;
    end
  end

  // one write at a time: ready returns only after the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? RESP_OKAY : RESP_ERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // write decode; narrow registers live in byte lane zero
  // ------------------------------------------------------------------
  always_comb begin
    wr_fire  = aw_held && w_held && !bvalid;
    wr_idx   = aw_addr[9:2];
    lane0    = w_strb[0];
    // only writable registers answer OKAY; ignored full-FIFO writes still do
    wr_hit   = (wr_idx == IDX_DATA) || (wr_idx == IDX_CTRL) ||
               (wr_idx == IDX_COUNT);
    data_wr  = wr_fire && lane0 && wr_idx == IDX_DATA && armed != ARMED_BOTH;
    count_wr = wr_fire && lane0 && wr_idx == IDX_COUNT && armed != ARMED_BOTH;
    ctrl_wr  = wr_fire && lane0 && wr_idx == IDX_CTRL;
  end

  // flush is a pulse, so the bit never reads back as set
  assign flush   = ctrl_wr && w_data[BIT_FLUSH];
  // manual marker and pointer moves only count with automatic mode off
  assign man_adv = ctrl_wr && !auto_transmit_management && w_data[BIT_ADV];
  assign man_rev = ctrl_wr && !auto_transmit_management && w_data[BIT_REV];

  // mode bits are not reset by a flush; the flushing control write loads them too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      iso <= ISO_RESET;
      auto_transmit_management <= ATM_RESET;
    end else if (ctrl_wr) begin
      iso <= w_data[BIT_ISO];
      auto_transmit_management <= w_data[BIT_ATM];
    end
  end

  // ------------------------------------------------------------------
  // set selection
  // ------------------------------------------------------------------
  always_comb begin
    write_set = (armed == ARMED_ZERO);
    // with both or no set armed, order names the older set
    unique case (armed)
      ARMED_ZERO: send_set = 1'b0;
      ARMED_ONE:  send_set = 1'b1;
      ARMED_NONE: send_set = order;
      ARMED_BOTH: send_set = order;
    endcase
  end

  // ------------------------------------------------------------------
  // byte-count ring, one entry per set; a zero count is a null packet
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      count_ring[0] <= '0;
      count_ring[1] <= '0;
    end else if (count_wr) begin
      count_ring[write_set] <= w_data[COUNT_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // end of transfer actions by mode and outcome
  // ------------------------------------------------------------------
  always_comb begin
    done_adv   = 1'b0;
    done_rev   = 1'b0;
    done_clear = 1'b0;
    done_defer = 1'b0;
    // both status bits at once are taken as an acknowledge
    if (fi_done && auto_transmit_management && (fi_ack || fi_err)) begin
      if (iso) begin
        done_adv   = 1'b1;
        done_defer = 1'b1;
      end else if (fi_ack) begin
        done_adv   = 1'b1;
        done_clear = 1'b1;
      end else begin
        done_rev   = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // armed flags: clears first, then the count write, so a set wins
  // ------------------------------------------------------------------
  always_comb begin
    next_armed    = armed;
    next_order    = order;
    next_pend     = pend;
    next_pend_set = pend_set;
    if (flush) begin
      next_armed = ARMED_NONE;
      next_order = 1'b0;
      next_pend  = 1'b0;
    end else begin
      if (sof && pend) begin
        next_armed[pend_set] = 1'b0;
        next_pend            = 1'b0;
      end
      if (done_clear || man_adv) begin
        next_armed[send_set] = 1'b0;
      end
      if (done_defer) begin
        next_pend     = 1'b1;
        next_pend_set = send_set;
      end
      if (count_wr) begin
        next_order            = next_armed[~write_set] ? ~write_set : write_set;
        next_armed[write_set] = 1'b1;
      end
    end
  end

  // marker moves this cycle, flags change at the same edge: both update together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed    <= ARMED_NONE;
      order    <= 1'b0;
      pend     <= 1'b0;
      pend_set <= 1'b0;
    end else begin
      armed    <= next_armed;
      order    <= next_order;
      pend     <= next_pend;
      pend_set <= next_pend_set;
    end
  end

  // outcome of the last transfer, shown to firmware
  // a transfer ending in the flush cycle wins, so its outcome is not lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_ack <= 1'b0;
      last_err <= 1'b0;
    end else if (fi_done) begin
      last_ack <= fi_ack;
      last_err <= fi_err;
    end else if (flush) begin
      last_ack <= 1'b0;
      last_err <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // function interface side; length of the set next to send
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fi_count     <= '0;
      fi_set_ready <= 1'b0;
    end else begin
      fi_count     <= count_ring[send_set];
      fi_set_ready <= (armed != ARMED_NONE);
    end
  end

  // byte comes straight from the ring's output register
  assign fi_byte = rif.rd_data;

  // ------------------------------------------------------------------
  // read decode; the data port is write-only and reads as zero
  // ------------------------------------------------------------------
  always_comb begin
    rd_idx  = araddr[9:2];
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      IDX_DATA:  rd_word = '0;
      IDX_CTRL: begin
        rd_word[BIT_ISO] = iso;
        rd_word[BIT_ATM] = auto_transmit_management;
      end
      IDX_COUNT: rd_word[COUNT_W-1:0] = count_ring[send_set];
      IDX_FLAGS: rd_word[1:0] = armed;
      IDX_STAT: begin
        rd_word[BIT_ACK] = last_ack;
        rd_word[BIT_ERR] = last_err;
      end
      default:   rd_hit = 1'b0;
    endcase
  end

  // read answer registered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? RESP_OKAY : RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

endmodule

//--- tb/tx_set_manager_asserts.sv
// port-level assertion checker for the transmit data set manager
module tx_set_manager_asserts
  import txset_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        fi_byte_rd,
  input wire logic [7:0]  fi_byte,
  input wire logic        fi_set_ready,
  input wire logic        fi_done,
  input wire logic        fi_ack,
  input wire logic        fi_err,
  input wire logic        sof
);
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------------------------------------------------------------
  // bus handshakes
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  wr_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  ready_back_a: assert property (bvalid && bready |=> !awready ##1 awready)
    else $error("write ready not returned");

  // --------------------------------------------------------------------------
  // data set flags and byte output
  // --------------------------------------------------------------------------
  reset_idle_a: assert property ($rose(aresetn) |-> !fi_set_ready && !bvalid && !rvalid)
    else $error("outputs busy after reset");
  arm_by_count_a: assert property ($rose(fi_set_ready) |-> $past(bvalid))
    else $error("set armed without a register write");
  idle_end_a: assert property (fi_done && !fi_ack && !fi_err && !sof && awready
    |=> ##1 $stable(fi_set_ready))
    else $error("outcome-free transfer end changed flags");
  byte_hold_a: assert property (!fi_byte_rd |=> $stable(fi_byte))
    else $error("byte output moved without a read");
endmodule

bind tx_set_manager tx_set_manager_asserts i_tx_set_manager_asserts (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .fi_byte_rd(fi_byte_rd), .fi_byte(fi_byte), .fi_set_ready(fi_set_ready),
  .fi_done(fi_done), .fi_ack(fi_ack), .fi_err(fi_err), .sof(sof)
);

//--- tb/fi_model.sv
// behavioural model of the function interface that drains data sets
module fi_model (
  input  wire logic       aclk,
  input  wire logic [7:0] fi_byte,
  output var  logic       fi_byte_rd,
  output var  logic       fi_done,
  output var  logic       fi_ack,
  output var  logic       fi_err,
  output var  logic       sof
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle levels; outcome lines only mean something beside a done pulse
  initial begin
    fi_byte_rd = 1'b0;
    fi_done    = 1'b0;
    fi_ack     = 1'b0;
    fi_err     = 1'b0;
    sof        = 1'b0;
  end

  // one pulse per byte; the byte is taken once the pulse edge has landed
  task automatic pull(output logic [7:0] b);
    @(posedge aclk) fi_byte_rd <= 1'b1;
    @(posedge aclk) fi_byte_rd <= 1'b0;
    #1 b = fi_byte;
  endtask

  // end of transfer; outcome lines flip afterwards so stale levels are not trusted
  task automatic finish(input logic ack, input logic err);
    @(posedge aclk) begin
      fi_done <= 1'b1;
      fi_ack  <= ack;
      fi_err  <= err;
    end
    @(posedge aclk) begin
      fi_done <= 1'b0;
      fi_ack  <= ~ack;
      fi_err  <= ~err;
    end
  endtask

  // start-of-frame marker, one cycle
  task automatic frame;
    @(posedge aclk) sof <= 1'b1;
    @(posedge aclk) sof <= 1'b0;
  endtask
endmodule

//--- tb/tb_tx_set_manager.sv
// self-checking bench for the transmit data set manager
module tb_tx_set_manager
  import txset_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(nm, e, a) \
    begin \
      n_checks++; \
      if ((a) !== (e)) begin \
        num_errors++; \
        $display("BAD %s exp %h got %h", nm, e, a); \
      end \
    end

  logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, fi_byte_rd, fi_set_ready;
  logic              fi_done, fi_ack, fi_err, sof;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, r;
  logic [7:0]        fi_byte;
  logic [4:0]        fi_count;
  int                num_errors = 0;
  int                n_checks = 0;

  tx_set_manager i_tx_set_manager (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fi_byte_rd(fi_byte_rd), .fi_byte(fi_byte), .fi_count(fi_count),
    .fi_set_ready(fi_set_ready), .fi_done(fi_done), .fi_ack(fi_ack), .fi_err(fi_err),
    .sof(sof));

  fi_model i_fi_model (.aclk(aclk), .fi_byte(fi_byte), .fi_byte_rd(fi_byte_rd),
    .fi_done(fi_done), .fi_ack(fi_ack), .fi_err(fi_err), .sof(sof));

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // --------------------------------------------------------------------------
  // bus tasks; every wait is bounded so a stuck slave ends the run
  // --------------------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    int i;
    @(posedge aclk);
    awaddr  <= {2'h0, idx, 2'h0};
    awvalid <= 1'b1;
    wdata   <= {24'h0, v};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (i == 40) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (i == 40) begin
      num_errors++;
      conclude();
    end
  endtask

  task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(idx, v, rs);
    `CHK(nm, e, v)
  endtask

  // data bytes go in before the count of their set is written
  task automatic load(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) wr(IDX_DATA, base + 8'(i));
  endtask

  // drain n bytes and compare with the pattern that was loaded
  task automatic pb(input int n, input logic [7:0] base);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      i_fi_model.pull(b);
      `CHK("fi_byte", base + 8'(i), b)
    end
  endtask

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc("flags", IDX_FLAGS, ARMED_NONE);
    wr(IDX_FLAGS, 8'h03);
    `CHK("bresp", RESP_ERR, r)
    rc("flags", IDX_FLAGS, ARMED_NONE);
    rc("ctrl", IDX_CTRL, 32'h04);
    rd(8'h10, d, r);
    `CHK("rresp", RESP_ERR, r)
    load(3, 8'hA0);
    rc("flags", IDX_FLAGS, ARMED_NONE);
    wr(IDX_COUNT, 8'h03);
    rc("flags", IDX_FLAGS, ARMED_ZERO);
    rc("count", IDX_COUNT, 32'h03);
    `CHK("fi_count", 5'h03, fi_count)
    `CHK("fi_set_ready", 1'b1, fi_set_ready)
    load(2, 8'hB0);
    wr(IDX_COUNT, 8'h02);
    rc("flags", IDX_FLAGS, ARMED_BOTH);
    wr(IDX_DATA, 8'hEE);
    wr(IDX_COUNT, 8'h07);
    `CHK("bresp", RESP_OKAY, r)
    rc("count", IDX_COUNT, 32'h03);
    pb(3, 8'hA0);
    i_fi_model.finish(1'b1, 1'b0);
    rc("flags", IDX_FLAGS, ARMED_ONE);
    `CHK("fi_count", 5'h02, fi_count)
    wr(IDX_COUNT, 8'h00);
    rc("flags", IDX_FLAGS, ARMED_BOTH);
    i_fi_model.finish(1'b0, 1'b0);
    rc("flags", IDX_FLAGS, ARMED_BOTH);
    pb(2, 8'hB0);
    i_fi_model.finish(1'b0, 1'b1);
    rc("flags", IDX_FLAGS, ARMED_BOTH);
    rc("stat", IDX_STAT, 32'h02);
    pb(2, 8'hB0);
    i_fi_model.finish(1'b1, 1'b0);
    rc("flags", IDX_FLAGS, ARMED_ZERO);
    `CHK("fi_count", 5'h00, fi_count)
    i_fi_model.finish(1'b1, 1'b0);
    rc("flags", IDX_FLAGS, ARMED_NONE);
    wr(IDX_CTRL, 8'h00);
    load(1, 8'hC0);
    wr(IDX_COUNT, 8'h01);
    pb(1, 8'hC0);
    i_fi_model.finish(1'b1, 1'b0);
    i_fi_model.finish(1'b0, 1'b1);
    rc("flags", IDX_FLAGS, ARMED_ZERO);
    wr(IDX_CTRL, 8'h84);
    rc("flags", IDX_FLAGS, ARMED_NONE);
    rc("ctrl", IDX_CTRL, 32'h04);
    wr(IDX_CTRL, 8'h0C);
    load(2, 8'hD0);
    wr(IDX_COUNT, 8'h02);
    load(1, 8'hE0);
    wr(IDX_COUNT, 8'h01);
    pb(2, 8'hD0);
    i_fi_model.finish(1'b0, 1'b1);
    rc("flags", IDX_FLAGS, ARMED_BOTH);
    i_fi_model.frame();
    rc("flags", IDX_FLAGS, ARMED_ONE);
    pb(1, 8'hE0);
    i_fi_model.finish(1'b1, 1'b0);
    i_fi_model.frame();
    rc("flags", IDX_FLAGS, ARMED_NONE);
    `CHK("fi_set_ready", 1'b0, fi_set_ready)
    conclude();
  end
endmodule
